// file: inc/clk_fanout_pkg.sv
// Shared constants, types and register map of the dual bank clock fanout.
package clk_fanout_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_BANKS = 2;
    localparam int OUTS_PER_BANK = 4;
    localparam int REG_COUNT = 16;
    localparam int REG_ADDR_W = 4;
    localparam int RATIO_W = 9;
    localparam int BLOCK_MAX = 16;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------------
    // Register offsets and reset value
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_DEVICE = 4'h0;
    localparam logic [3:0] REG_BANK_CTL = 4'h1;
    localparam logic [3:0] REG_BANK_A_OUT0 = 4'h2;
    localparam logic [3:0] REG_BANK_B_OUT0 = 4'h6;
    localparam logic [3:0] REG_DIV_A_HI = 4'hc;
    localparam logic [3:0] REG_DIV_A_LO = 4'hd;
    localparam logic [3:0] REG_DIV_B_HI = 4'he;
    localparam logic [3:0] REG_DIV_B_LO = 4'hf;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DEV_SEL_A = 5;
    localparam int DEV_SEL_B = 6;
    localparam int DEV_SEL_REG = 4;
    localparam int CTL_DIS_A = 5;
    localparam int CTL_DIS_B = 4;
    localparam int CTL_PDN_A = 3;
    localparam int CTL_PDN_B = 2;
    localparam int DIV_HI_BIT = 0;
    localparam int OUT_CFG_W = 7;
    localparam logic [8:0] RATIO_MIN = 9'h002;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DRV_LVDS = 3'h0,
        DRV_LVCMOS = 3'h1,
        DRV_LVPECL = 3'h2,
        DRV_CML = 3'h3,
        DRV_HCSL = 3'h4
    } drv_type_e;

    typedef enum logic [3:0] {
        SPI_CMD = 4'h1,
        SPI_WRITE = 4'h2,
        SPI_READ = 4'h4,
        SPI_HOLD = 4'h8
    } spi_state_e;

    // Per output configuration, same bit order as its register [6:0].
    typedef struct packed {
        logic power_off;
        logic single_output_disable;
        logic lvcmos_inverted;
        logic cml_swing_800;
        drv_type_e drv;
    } out_cfg_s;

    // One output pair as seen by its driver.
    typedef struct packed {
        logic true_pin;
        logic complement_output_pin;
        logic drive_en;
    } pin_out_s;

    // Asynchronous pins, synchronised together.
    typedef struct packed {
        logic first_ref;
        logic second_ref;
        logic ref_sel;
        logic global_oe;
        logic spi_mode;
        logic sclk;
        logic cs_n;
        logic sdi;
    } pins_s;

endpackage

// file: hdl/bank_divider.sv
// One bank divider with bypass, power down and glitch-free enable.
`timescale 1ns/1ps

module bank_divider
    import clk_fanout_pkg::*;
#(
    parameter int DIV_W = RATIO_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic ref_in,
    input wire logic [DIV_W-1:0] ratio,
    input wire logic power_down,
    input wire logic enable,
    output logic bank_clk,
    output logic bank_on
);

    logic ref_d;
    logic div_clk;
    logic en_q;
    logic bypass;
    logic next_div;
    logic [DIV_W:0] cnt;
    logic [DIV_W:0] next_cnt;

    // Ratios 0 and 1 mean bypass; 2 and up divide by that integer.
    assign bypass = ratio < DIV_W'(RATIO_MIN);

    // Count half periods of the reference; high for the first half.
    always_comb begin
        next_cnt = cnt + (DIV_W + 1)'(1);
        if (cnt >= {ratio, 1'b0} - (DIV_W + 1)'(1)) begin
            next_cnt = '0;
        end
        next_div = next_cnt < {1'b0, ratio};
    end

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Power down clears the counter and the divided clock so the bank logic stops toggling.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_d <= 1'b0;
            cnt <= '0;
            div_clk <= 1'b0;
        end else if (ce) begin
            ref_d <= ref_in;
            if (power_down) begin
                cnt <= '0;
                div_clk <= 1'b0;
            end else if (bypass) begin
                cnt <= '0;
                div_clk <= ref_in;
            end else if (ref_in ^ ref_d) begin
                cnt <= next_cnt;
                div_clk <= next_div;
            end
        end
    end

    // ------------------------------------------------------------------
    // Glitch-free enable
    // ------------------------------------------------------------------
    // The enable is only taken while the divided clock is low, so a pulse
    // is either passed whole or not at all.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (ce) begin
            if (power_down) begin
                en_q <= 1'b0;
            end else if (!div_clk) begin
                en_q <= enable;
            end
        end
    end

    assign bank_clk = div_clk & en_q;
    assign bank_on = en_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PDN_STOPS: assert property (
        ce && power_down |=> !div_clk && !bank_on)
        else $error("powered down bank still toggles");

    AST_BYPASS_FOLLOWS: assert property (
        ce && bypass && !power_down |=> div_clk == $past(ref_in))
        else $error("bypass does not follow the reference");

    AST_NO_RUNT: assert property (
        $changed(en_q) && !$past(power_down) |-> !$past(div_clk))
        else $error("enable changed while the clock was high");

endmodule

// file: hdl/clk_fanout_ctrl.sv
// Control logic of a two input, two bank clock fanout with SPI setup port.
`timescale 1ns/1ps

module clk_fanout_ctrl
    import clk_fanout_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic first_reference_input,
    input wire logic second_reference_input,
    input wire logic ref_select_pin,
    input wire logic global_oe,
    input wire logic port_protocol_select,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic i2c_addr_bit0,
    output pin_out_s [OUTS_PER_BANK-1:0] bank_a_outputs,
    output pin_out_s [OUTS_PER_BANK-1:0] bank_b_outputs,
    output out_cfg_s [OUTS_PER_BANK-1:0] bank_a_config,
    output out_cfg_s [OUTS_PER_BANK-1:0] bank_b_config
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [REG_ADDR_W-1:0] next_addr(
        input logic [REG_ADDR_W-1:0] a
    );
        next_addr = a + REG_ADDR_W'(1);
    endfunction

    function automatic logic pick_ref(input logic sel, input pins_s p);
        pick_ref = sel ? p.second_ref : p.first_ref;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pins_s pins_raw;
    pins_s pins_meta;
    pins_s pins_s1;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;
    logic spi_active;
    spi_state_e state;
    logic [2:0] bit_cnt;
    logic [4:0] byte_cnt;
    logic [BYTE_W-1:0] shift;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] tx;
    logic [REG_ADDR_W-1:0] addr;
    logic wr_en;
    logic [BYTE_W-1:0] regs [REG_COUNT];
    logic sel_a;
    logic sel_b;
    logic [NUM_BANKS-1:0] bank_enable;
    logic [NUM_BANKS-1:0] bank_pdn;
    logic [NUM_BANKS-1:0] bank_clk;
    logic [NUM_BANKS-1:0] bank_on;
    logic [NUM_BANKS-1:0] bank_ref;
    logic [RATIO_W-1:0] ratio [NUM_BANKS];
    out_cfg_s cfg [NUM_BANKS][OUTS_PER_BANK];
    pin_out_s next_pin [NUM_BANKS][OUTS_PER_BANK];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins_raw.first_ref = first_reference_input;
    assign pins_raw.second_ref = second_reference_input;
    assign pins_raw.ref_sel = ref_select_pin;
    assign pins_raw.global_oe = global_oe;
    assign pins_raw.spi_mode = port_protocol_select;
    assign pins_raw.sclk = sclk;
    assign pins_raw.cs_n = cs_n;
    assign pins_raw.sdi = sdi;

    // All pins share one latency, so SDI stays aligned with SCLK.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta <= '0;
            pins_s1 <= '0;
        end else if (ce) begin
            pins_meta <= pins_raw;
            pins_s1 <= pins_meta;
        end
    end

    // Serial clock edges are found on the synchronised copy only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
        end else if (ce) begin
            sclk_d <= pins_s1.sclk;
        end
    end

    assign sclk_rise = ce & pins_s1.sclk & ~sclk_d;
    assign sclk_fall = ce & ~pins_s1.sclk & sclk_d;
    // Protocol high selects SPI; chip select frames it, active low.
    assign spi_active = pins_s1.spi_mode & ~pins_s1.cs_n;
    assign rx_byte = {shift[BYTE_W-2:0], pins_s1.sdi};
    assign wr_en = sclk_rise && spi_active && state == SPI_WRITE
                   && &bit_cnt;

    // ------------------------------------------------------------------
    // SPI frame sequencer
    // ------------------------------------------------------------------
    // Command byte: read/write bit first, register address in low bits.
    // Writes stop taking bytes after a block of sixteen; reads run on.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SPI_CMD;
            bit_cnt <= '0;
            byte_cnt <= '0;
            shift <= '0;
            addr <= '0;
        end else if (!spi_active) begin
            if (ce) begin
                state <= SPI_CMD;
                bit_cnt <= '0;
                byte_cnt <= '0;
            end
        end else if (sclk_rise) begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            case (state)
                SPI_CMD: begin
                    if (&bit_cnt) begin
                        addr <= rx_byte[REG_ADDR_W-1:0];
                        state <= shift[BYTE_W-2] ? SPI_READ : SPI_WRITE;
                    end
                end
                SPI_WRITE: begin
                    if (&bit_cnt) begin
                        addr <= next_addr(addr);
                        byte_cnt <= byte_cnt + 5'h01;
                        if (byte_cnt == 5'(BLOCK_MAX - 1)) begin
                            state <= SPI_HOLD;
                        end
                    end
                end
                SPI_READ: begin
                    if (&bit_cnt) begin
                        addr <= next_addr(addr);
                    end
                end
                default: begin
                    state <= SPI_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------
    // The byte is fetched on the last rising edge of the previous byte and
    // presented MSB first on the following falling edges.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= '0;
            sdo <= 1'b0;
        end else if (spi_active) begin
            if (sclk_rise && &bit_cnt) begin
                if (state == SPI_CMD) begin
                    tx <= regs[rx_byte[REG_ADDR_W-1:0]];
                end else begin
                    tx <= regs[next_addr(addr)];
                end
            end else if (sclk_fall && state == SPI_READ) begin
                sdo <= tx[BYTE_W-1];
                tx <= {tx[BYTE_W-2:0], 1'b0};
            end
        end
    end

    // SDO drives only inside a read frame; I2C sees the address strap.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_oe <= 1'b0;
            i2c_addr_bit0 <= 1'b0;
        end else if (ce) begin
            sdo_oe <= spi_active && state == SPI_READ;
            i2c_addr_bit0 <= ~pins_s1.spi_mode & pins_s1.cs_n;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // All zero at reset: LVDS, enabled, dividers bypassed, pin selection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < REG_COUNT; r++) begin
                regs[r] <= REG_RESET;
            end
        end else if (wr_en) begin
            regs[addr] <= rx_byte;
        end
    end

    // ------------------------------------------------------------------
    // Reference selection and bank controls
    // ------------------------------------------------------------------
    always_comb begin
        if (regs[REG_DEVICE][DEV_SEL_REG]) begin
            sel_a = regs[REG_DEVICE][DEV_SEL_A];
            sel_b = regs[REG_DEVICE][DEV_SEL_B];
        end else begin
            sel_a = pins_s1.ref_sel;
            sel_b = pins_s1.ref_sel;
        end
    end

    assign bank_ref[0] = pick_ref(sel_a, pins_s1);
    assign bank_ref[1] = pick_ref(sel_b, pins_s1);
    assign ratio[0] = {regs[REG_DIV_A_HI][DIV_HI_BIT], regs[REG_DIV_A_LO]};
    assign ratio[1] = {regs[REG_DIV_B_HI][DIV_HI_BIT], regs[REG_DIV_B_LO]};
    // Global enable and bank bit both pass the glitch-free gate.
    assign bank_enable[0] = pins_s1.global_oe
                            & ~regs[REG_BANK_CTL][CTL_DIS_A];
    assign bank_enable[1] = pins_s1.global_oe
                            & ~regs[REG_BANK_CTL][CTL_DIS_B];
    assign bank_pdn[0] = regs[REG_BANK_CTL][CTL_PDN_A];
    assign bank_pdn[1] = regs[REG_BANK_CTL][CTL_PDN_B];

    // ------------------------------------------------------------------
    // Bank dividers
    // ------------------------------------------------------------------
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        bank_divider #(
            .DIV_W(RATIO_W)
        ) u_div (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .ref_in(bank_ref[b]),
            .ratio(ratio[b]),
            .power_down(bank_pdn[b]),
            .enable(bank_enable[b]),
            .bank_clk(bank_clk[b]),
            .bank_on(bank_on[b])
        );
    end

    // ------------------------------------------------------------------
    // Output pins and driver configuration
    // ------------------------------------------------------------------
    // Single output bits act directly on the pins, so they may clip a
    // pulse; software is expected to park the bank first.
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            for (int i = 0; i < OUTS_PER_BANK; i++) begin
                cfg[b][i] = out_cfg_s'(regs[(b == 0 ? REG_BANK_A_OUT0
                            : REG_BANK_B_OUT0) + 4'(i)][OUT_CFG_W-1:0]);
                next_pin[b][i].drive_en = bank_on[b]
                    & ~cfg[b][i].single_output_disable
                    & ~cfg[b][i].power_off;
                next_pin[b][i].true_pin = bank_clk[b]
                    & next_pin[b][i].drive_en;
                if (cfg[b][i].drv == DRV_LVCMOS
                        && !cfg[b][i].lvcmos_inverted) begin
                    next_pin[b][i].complement_output_pin =
                        next_pin[b][i].true_pin;
                end else begin
                    next_pin[b][i].complement_output_pin =
                        ~bank_clk[b] & next_pin[b][i].drive_en;
                end
            end
        end
    end

    // Registered pins; driver type and CML swing go to the pad drivers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_a_outputs <= '0;
            bank_b_outputs <= '0;
            bank_a_config <= '0;
            bank_b_config <= '0;
        end else if (ce) begin
            for (int i = 0; i < OUTS_PER_BANK; i++) begin
                bank_a_outputs[i] <= next_pin[0][i];
                bank_b_outputs[i] <= next_pin[1][i];
                bank_a_config[i] <= cfg[0][i];
                bank_b_config[i] <= cfg[1][i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SEL_PIN: assert property (
        !regs[REG_DEVICE][DEV_SEL_REG] |->
        bank_ref[0] == (pins_s1.ref_sel ? pins_s1.second_ref
                        : pins_s1.first_ref) && bank_ref[1] == bank_ref[0])
        else $error("pin selection not applied to both dividers");

    AST_SEL_REG: assert property (
        regs[REG_DEVICE][DEV_SEL_REG] |->
        sel_a == regs[REG_DEVICE][DEV_SEL_A]
        && sel_b == regs[REG_DEVICE][DEV_SEL_B])
        else $error("register selection not applied");

    AST_OE_HIZ: assert property (
        ce && !bank_on[0] |=> !bank_a_outputs[0].drive_en)
        else $error("bank A output drives while bank is off");

    AST_GLOBAL_NO_RUNT: assert property (
        $changed(bank_on[1]) && !$past(bank_pdn[1]) |-> !$past(bank_clk[1]))
        else $error("bank B enable cut a pulse");

    AST_PWR_OFF: assert property (
        ce && cfg[1][1].power_off |=> bank_b_outputs[1] == '0)
        else $error("powered off output still active");

    AST_LVCMOS_PHASE: assert property (
        ce && cfg[0][0].drv == DRV_LVCMOS && !cfg[0][0].lvcmos_inverted
        |=> bank_a_outputs[0].complement_output_pin
            == bank_a_outputs[0].true_pin)
        else $error("in-phase LVCMOS pins differ");

    AST_WRITE_COMMIT: assert property (
        wr_en |=> regs[$past(addr)] == $past(rx_byte))
        else $error("written byte not committed");

    AST_WRITE_ON_RISE: assert property (
        wr_en |-> sclk_rise && spi_active)
        else $error("write outside a rising serial edge");

    AST_BLOCK_LIMIT: assert property (
        wr_en && byte_cnt == 5'(BLOCK_MAX - 1) |=> state == SPI_HOLD)
        else $error("write accepted beyond the block limit");

    AST_SDO_ON_FALL: assert property (
        spi_active && $past(spi_active) && $changed(sdo)
        |-> $past(sclk_fall))
        else $error("SDO changed away from a falling edge");

    COV_WRITE: cover property (wr_en ##[1:200] wr_en);
    COV_READ: cover property (state == SPI_READ && sclk_fall);
    COV_HOLD: cover property (state == SPI_HOLD);
    COV_BANK_OFF: cover property ($fell(bank_on[0]));

endmodule

// file: verification/spi_host_model.sv
// SPI host model that frames, shifts and samples the setup port.
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    // Idle: deselected with the serial clock parked low.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // Each level lasts five clk cycles, above the three the port needs.
    task automatic half();
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Chip select is active low and frames the whole transfer.
    task automatic start();
        cs_n = 1'b0;
        half();
    endtask
    // A released data line shows the inverse so stale bits cannot pass.
    task automatic stop();
        half();
        cs_n = 1'b1;
        sdi = ~sdi;
        half();
    endtask
    // MSB first; data moves while the clock is low, sdo read before rise.
    task automatic put(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sdi = b[i];
            half();
            r[i] = sdo;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the clock fanout control block.
`timescale 1ns/1ps
module testbench
    import clk_fanout_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, first_ref = 1'b0, second_ref = 1'b0;
    logic sel_pin = 1'b0, oe = 1'b1, sdo, sdo_oe, addr_bit0;
    logic sclk, cs_n, sdi, spi_sel = 1'b1;
    logic [7:0] rd;
    pin_out_s [3:0] qa, qb;
    out_cfg_s [3:0] ca, cb;
    int failures = 0, n_tests = 0;
    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end
    spi_host_model spi_host_model_i (.clk(clk), .sdo(sdo), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi));
    clk_fanout_ctrl clk_fanout_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .first_reference_input(first_ref), .second_reference_input(second_ref),
        .ref_select_pin(sel_pin), .global_oe(oe),
        .port_protocol_select(spi_sel),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .i2c_addr_bit0(addr_bit0), .bank_a_outputs(qa), .bank_b_outputs(qb),
        .bank_a_config(ca), .bank_b_config(cb));
    // Verdict and end of run, shared by the main sequence and the watchdog.
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pins pass two synchronisers and the divider, so allow ten cycles.
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        spi_host_model_i.start();
        spi_host_model_i.put({4'h0, a}, rd);
        spi_host_model_i.put(d, rd);
        spi_host_model_i.stop();
    endtask
    task automatic mux(input logic ea, input logic eb);
        settle();
        chk({6'h0, qa[0].true_pin, qb[0].true_pin}, {6'h0, ea, eb});
    endtask
    // Watchdog: a hang counts as a mismatch and ends the run.
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        settle();
        chk({1'b0, ca[0]}, 8'h00);
        chk({6'h0, qa[3].drive_en, qb[3].drive_en}, 8'h03);
        first_ref = 1'b1;
        mux(1'b1, 1'b1);
        sel_pin = 1'b1;
        mux(1'b0, 1'b0);
        $display("test reset and pin select done");
        for (int s = 0; s < 4; s++) begin
            wr(4'h0, 8'h10 | 8'(s << 5));
            mux(~s[0], ~s[1]);
        end
        $display("test register select done");
        spi_host_model_i.start();
        spi_host_model_i.put(8'h00, rd);
        spi_host_model_i.put(8'h00, rd);
        spi_host_model_i.put(8'h00, rd);
        settle();
        chk({1'b0, ca[0]}, 8'h00);
        spi_host_model_i.put(8'h01, rd);
        settle();
        chk({1'b0, ca[0]}, 8'h01);
        spi_host_model_i.stop();
        second_ref = 1'b1;
        settle();
        chk({7'h0, qa[0].complement_output_pin}, 8'h01);
        chk({6'h0, qa[1].true_pin, qa[1].complement_output_pin}, 8'h02);
        spi_host_model_i.start();
        spi_host_model_i.put(8'h82, rd);
        chk({7'h0, sdo_oe}, 8'h01);
        spi_host_model_i.put(8'h00, rd);
        spi_host_model_i.stop();
        chk(rd, 8'h01);
        chk({7'h0, sdo_oe}, 8'h00);
        $display("test block write and read done");
        // Divide by two: every sample is inverted two half-periods later.
        wr(4'hd, 8'h02);
        for (int k = 0; k < 10; k++) begin
            second_ref = ~second_ref;
            settle();
            rd = {rd[6:0], qa[0].true_pin};
        end
        chk({2'h0, rd[5:0] ^ rd[7:2]}, 8'h3f);
        wr(4'hd, 8'h00);
        $display("test divider done");
        second_ref = 1'b0;
        first_ref = 1'b0;
        wr(4'h1, 8'h20);
        settle();
        chk({6'h0, qa[0].drive_en, qb[0].drive_en}, 8'h01);
        wr(4'h3, 8'h20);
        wr(4'h1, 8'h00);
        settle();
        chk({6'h0, qa[1].drive_en, qa[0].drive_en}, 8'h01);
        wr(4'h7, 8'h40);
        settle();
        chk({6'h0, qb[1].drive_en, qb[0].drive_en}, 8'h01);
        wr(4'h1, 8'h04);
        settle();
        chk({6'h0, qa[0].drive_en, qb[0].drive_en}, 8'h02);
        wr(4'h1, 8'h00);
        oe = 1'b0;
        settle();
        chk({6'h0, qa[0].drive_en, qb[0].drive_en}, 8'h00);
        $display("test enables done");
        // Seventeen bytes from address A: the last one must not land.
        spi_host_model_i.start();
        for (int k = 0; k < 18; k++) begin
            spi_host_model_i.put(k == 0 ? 8'h0a : k == 16 ? 8'h01
                : k == 17 ? 8'hff : 8'h00, rd);
        end
        spi_host_model_i.stop();
        spi_host_model_i.start();
        spi_host_model_i.put(8'h8a, rd);
        spi_host_model_i.put(8'h00, rd);
        spi_host_model_i.stop();
        chk(rd, 8'h00);
        chk({1'b0, cb[3]}, 8'h01);
        $display("test block limit done");
        // Low protocol select: chip select is an address strap, no SPI.
        spi_sel = 1'b0;
        settle();
        chk({7'h0, addr_bit0}, 8'h01);
        wr(4'h9, 8'h00);
        settle();
        chk({1'b0, cb[3]}, 8'h01);
        $display("test protocol select done");
        end_of_test();
    end
endmodule
